/* File: src/rta_pkg.sv */
// constants for the alarm match, alarm pin and interrupt request block
package rta_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PRESC_W = 15;
    // register byte offsets
    localparam logic [7:0] OFS_CAL_CTRL = 8'h00;
    localparam logic [7:0] OFS_ALARM_CTRL = 8'h04;
    localparam logic [7:0] OFS_ALARM_TIME = 8'h08;
    localparam logic [7:0] OFS_ALARM_DATE = 8'h0C;
    localparam logic [7:0] OFS_CAL_TIME = 8'h10;
    localparam logic [7:0] OFS_CAL_DATE = 8'h14;
    localparam logic [7:0] OFS_IRQ_FLAG = 8'h20;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h24;
    localparam logic [7:0] OFS_IRQ_PRIORITY = 8'h28;
    // calendar_control_reg fields
    localparam int CC_ON = 15;
    localparam int CC_PIN_SEL = 7;
    localparam int CC_PIN_OE = 0;
    // alarm_control_reg fields
    localparam int AC_ENABLE = 15;
    localparam int AC_ENDLESS = 14;
    localparam int AC_INIT_LVL = 13;
    localparam int AC_SYNC_BUSY = 12;
    localparam int AC_MASK_HI = 11;
    localparam int AC_MASK_LO = 8;
    localparam int AC_RPT_HI = 7;
    localparam int AC_RPT_LO = 0;
    // interrupt flag, enable and priority fields
    localparam int IF_ALARM = 15;
    localparam int IE_ALARM = 15;
    localparam int IP_PRIO_HI = 28;
    localparam int IP_PRIO_LO = 26;
    localparam int IP_SUB_HI = 25;
    localparam int IP_SUB_LO = 24;
    // prescaler points
    localparam logic [14:0] PRESC_WRAP = 15'h0000;
    localparam logic [14:0] PRESC_HALF = 15'h4000;
    localparam logic [6:0] BUSY_WINDOW = 7'h7F;
    // interrupt identity of the alarm source
    localparam logic [5:0] ALARM_VECTOR = 6'h23;
    localparam logic [5:0] ALARM_IRQ_NUM = 6'h2F;
    localparam logic [2:0] PRIO_NONE = 3'h0;
    // match_mask interval codes
    localparam logic [3:0] MM_HALF_SEC = 4'h0;
    localparam logic [3:0] MM_SEC = 4'h1;
    localparam logic [3:0] MM_TEN_SEC = 4'h2;
    localparam logic [3:0] MM_MINUTE = 4'h3;
    localparam logic [3:0] MM_TEN_MIN = 4'h4;
    localparam logic [3:0] MM_HOUR = 4'h5;
    localparam logic [3:0] MM_DAY = 4'h6;
    localparam logic [3:0] MM_WEEK = 4'h7;
    localparam logic [3:0] MM_MONTH = 4'h8;
    localparam logic [3:0] MM_YEAR = 4'h9;
    // digits compared per interval, time word hh:mm:ss:xx, date word yy:mm:dd:wd
    localparam logic [31:0] TM_NONE = 32'h0000_0000;
    localparam logic [31:0] TM_TEN_SEC = 32'h0000_0F00;
    localparam logic [31:0] TM_MINUTE = 32'h0000_FF00;
    localparam logic [31:0] TM_TEN_MIN = 32'h000F_FF00;
    localparam logic [31:0] TM_HOUR = 32'h00FF_FF00;
    localparam logic [31:0] TM_DAY = 32'hFFFF_FF00;
    localparam logic [31:0] DM_NONE = 32'h0000_0000;
    localparam logic [31:0] DM_WEEK = 32'h0000_00FF;
    localparam logic [31:0] DM_MONTH = 32'h0000_FF00;
    localparam logic [31:0] DM_YEAR = 32'h00FF_FF00;
endpackage

/* File: src/rta_alarm_irq.sv */
// alarm match, alarm pin output and alarm interrupt request logic
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module rta_alarm_irq (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    input wire logic [31:0] CAL_TIME,
    input wire logic [31:0] CAL_DATE,
    input wire logic [14:0] CAL_PRESCALER,
    input wire logic CAL_TICK,
    input wire logic [2:0] CPU_IPL,
    output logic CAL_ON,
    output logic ALARM_PIN,
    output logic ALARM_PIN_OE,
    output logic IRQ_FLAG,
    output logic IRQ_REQUEST,
    output logic IRQ_PREEMPT,
    output logic [2:0] IRQ_PRIORITY,
    output logic [1:0] IRQ_SUBPRIORITY,
    output logic [5:0] IRQ_VECTOR,
    output logic [5:0] IRQ_NUMBER
);

    typedef struct packed {
        logic cal_on;
        logic pin_sel;
        logic pin_oe;
        logic alm_en;
        logic endless;
        logic init_lvl;
        logic [3:0] mask;
        logic [7:0] rpt;
        logic [31:0] alm_time;
        logic [31:0] alm_date;
        logic flag;
        logic irq_en;
        logic [2:0] prio;
        logic [1:0] subprio;
        logic pend;
        logic pulse;
        logic sec_clk;
        logic pin;
        logic irq_req;
        logic irq_pre;
        logic [31:0] rdata;
    } rta_state_t;

    rta_state_t state_ff;
    rta_state_t nxt_state;

    logic [31:0] time_mask;
    logic [31:0] date_mask;
    logic boundary;
    logic digits_equal;
    logic alarm_event;
    logic sync_busy;
    logic irq_live;
    logic higher_group;
    logic pin_source;

    // digits compared and boundary used per interval code
    always_comb
    begin
        time_mask = rta_pkg::TM_NONE;
        date_mask = rta_pkg::DM_NONE;
        boundary = (CAL_PRESCALER == rta_pkg::PRESC_WRAP);
        digits_equal = 1'b1;
        case (state_ff.mask)
            rta_pkg::MM_HALF_SEC:
            begin
                boundary = (CAL_PRESCALER == rta_pkg::PRESC_WRAP)
                    || (CAL_PRESCALER == rta_pkg::PRESC_HALF);
            end
            rta_pkg::MM_SEC:
            begin
                time_mask = rta_pkg::TM_NONE;
            end
            rta_pkg::MM_TEN_SEC:
            begin
                time_mask = rta_pkg::TM_TEN_SEC;
            end
            rta_pkg::MM_MINUTE:
            begin
                time_mask = rta_pkg::TM_MINUTE;
            end
            rta_pkg::MM_TEN_MIN:
            begin
                time_mask = rta_pkg::TM_TEN_MIN;
            end
            rta_pkg::MM_HOUR:
            begin
                time_mask = rta_pkg::TM_HOUR;
            end
            rta_pkg::MM_DAY:
            begin
                time_mask = rta_pkg::TM_DAY;
            end
            rta_pkg::MM_WEEK:
            begin
                time_mask = rta_pkg::TM_DAY;
                date_mask = rta_pkg::DM_WEEK;
            end
            rta_pkg::MM_MONTH:
            begin
                time_mask = rta_pkg::TM_DAY;
                date_mask = rta_pkg::DM_MONTH;
            end
            rta_pkg::MM_YEAR:
            begin
                time_mask = rta_pkg::TM_DAY;
                date_mask = rta_pkg::DM_YEAR;
            end
            default:
            begin
                digits_equal = 1'b0;
            end
        endcase
        if (((CAL_TIME ^ state_ff.alm_time) & time_mask) != 32'h0000_0000)
        begin
            digits_equal = 1'b0;
        end
        if (((CAL_DATE ^ state_ff.alm_date) & date_mask) != 32'h0000_0000)
        begin
            digits_equal = 1'b0;
        end
    end

    // a held match becomes an event at the next calendar tick
    assign alarm_event = CAL_TICK && state_ff.pend && state_ff.alm_en;
    assign sync_busy = state_ff.cal_on && state_ff.alm_en
        && (state_ff.pend || (CAL_PRESCALER[14:8] == rta_pkg::BUSY_WINDOW));

    // request qualifiers toward the interrupt controller
    always_comb
    begin
        irq_live = 1'b0;
        higher_group = 1'b0;
        if (state_ff.flag && state_ff.irq_en)
        begin
            irq_live = (state_ff.prio != rta_pkg::PRIO_NONE);
        end
        if (state_ff.prio > CPU_IPL)
        begin
            higher_group = 1'b1;
        end
    end

    // pin source: seconds clock or alarm pulse
    always_comb
    begin
        if (state_ff.pin_sel)
        begin
            pin_source = state_ff.sec_clk;
        end
        else
        begin
            pin_source = state_ff.pulse;
        end
    end

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.rdata = 32'h0000_0000;
        // register reads, data valid in the following cycle
        if (REG_RD)
        begin
            case (REG_ADDR)
                rta_pkg::OFS_CAL_CTRL:
                begin
                    nxt_state.rdata[rta_pkg::CC_ON] = state_ff.cal_on;
                    nxt_state.rdata[rta_pkg::CC_PIN_SEL] = state_ff.pin_sel;
                    nxt_state.rdata[rta_pkg::CC_PIN_OE] = state_ff.pin_oe;
                end
                rta_pkg::OFS_ALARM_CTRL:
                begin
                    nxt_state.rdata[rta_pkg::AC_ENABLE] = state_ff.alm_en;
                    nxt_state.rdata[rta_pkg::AC_ENDLESS] = state_ff.endless;
                    nxt_state.rdata[rta_pkg::AC_INIT_LVL] = state_ff.init_lvl;
                    nxt_state.rdata[rta_pkg::AC_SYNC_BUSY] = sync_busy;
                    nxt_state.rdata[rta_pkg::AC_MASK_HI:rta_pkg::AC_MASK_LO] = state_ff.mask;
                    nxt_state.rdata[rta_pkg::AC_RPT_HI:rta_pkg::AC_RPT_LO] = state_ff.rpt;
                end
                rta_pkg::OFS_ALARM_TIME:
                begin
                    nxt_state.rdata = state_ff.alm_time;
                end
                rta_pkg::OFS_ALARM_DATE:
                begin
                    nxt_state.rdata = state_ff.alm_date;
                end
                rta_pkg::OFS_CAL_TIME:
                begin
                    nxt_state.rdata = CAL_TIME;
                end
                rta_pkg::OFS_CAL_DATE:
                begin
                    nxt_state.rdata = CAL_DATE;
                end
                rta_pkg::OFS_IRQ_FLAG:
                begin
                    nxt_state.rdata[rta_pkg::IF_ALARM] = state_ff.flag;
                end
                rta_pkg::OFS_IRQ_ENABLE:
                begin
                    nxt_state.rdata[rta_pkg::IE_ALARM] = state_ff.irq_en;
                end
                rta_pkg::OFS_IRQ_PRIORITY:
                begin
                    nxt_state.rdata[rta_pkg::IP_PRIO_HI:rta_pkg::IP_PRIO_LO] = state_ff.prio;
                    nxt_state.rdata[rta_pkg::IP_SUB_HI:rta_pkg::IP_SUB_LO] = state_ff.subprio;
                end
                default:
                begin
                    nxt_state.rdata = 32'h0000_0000;
                end
            endcase
        end
        // register writes
        if (REG_WR)
        begin
            case (REG_ADDR)
                rta_pkg::OFS_CAL_CTRL:
                begin
                    nxt_state.cal_on = REG_WDATA[rta_pkg::CC_ON];
                    nxt_state.pin_sel = REG_WDATA[rta_pkg::CC_PIN_SEL];
                    nxt_state.pin_oe = REG_WDATA[rta_pkg::CC_PIN_OE];
                end
                rta_pkg::OFS_ALARM_CTRL:
                begin
                    nxt_state.alm_en = REG_WDATA[rta_pkg::AC_ENABLE];
                    nxt_state.endless = REG_WDATA[rta_pkg::AC_ENDLESS];
                    nxt_state.init_lvl = REG_WDATA[rta_pkg::AC_INIT_LVL];
                    nxt_state.mask = REG_WDATA[rta_pkg::AC_MASK_HI:rta_pkg::AC_MASK_LO];
                    nxt_state.rpt = REG_WDATA[rta_pkg::AC_RPT_HI:rta_pkg::AC_RPT_LO];
                end
                rta_pkg::OFS_ALARM_TIME:
                begin
                    nxt_state.alm_time = REG_WDATA;
                end
                rta_pkg::OFS_ALARM_DATE:
                begin
                    nxt_state.alm_date = REG_WDATA;
                end
                rta_pkg::OFS_IRQ_FLAG:
                begin
                    nxt_state.flag = REG_WDATA[rta_pkg::IF_ALARM];
                end
                rta_pkg::OFS_IRQ_ENABLE:
                begin
                    nxt_state.irq_en = REG_WDATA[rta_pkg::IE_ALARM];
                end
                rta_pkg::OFS_IRQ_PRIORITY:
                begin
                    nxt_state.prio = REG_WDATA[rta_pkg::IP_PRIO_HI:rta_pkg::IP_PRIO_LO];
                    nxt_state.subprio = REG_WDATA[rta_pkg::IP_SUB_HI:rta_pkg::IP_SUB_LO];
                end
                default:
                begin
                    nxt_state.rdata = nxt_state.rdata;
                end
            endcase
        end
        // capture a match on a calendar tick; a write of the alarm may glitch it
        if (CAL_TICK)
        begin
            nxt_state.pend = state_ff.cal_on && state_ff.alm_en
                && boundary && digits_equal;
        end
        if (!state_ff.cal_on)
        begin
            nxt_state.pend = 1'b0;
        end
        // event: flag, repeat count and pulse; the set beats a software clear
        if (alarm_event)
        begin
            nxt_state.flag = 1'b1;
            nxt_state.pulse = !state_ff.pulse;
            nxt_state.rpt = state_ff.rpt - 8'h01;
            if ((state_ff.rpt == 8'h00) && !state_ff.endless)
            begin
                nxt_state.alm_en = 1'b0;
                nxt_state.rpt = 8'h00;
            end
        end
        // pulse held at the start level while off, and reloaded on the enabling write
        if (!state_ff.alm_en || !nxt_state.alm_en)
        begin
            nxt_state.pulse = nxt_state.init_lvl;
        end
        nxt_state.sec_clk = (CAL_PRESCALER < rta_pkg::PRESC_HALF);
        nxt_state.pin = pin_source;
        // request held while flag, enable and a nonzero priority all stand; one source, so no natural order contest
        nxt_state.irq_req = irq_live;
        // preemption needs a strictly higher group; subpriority never preempts
        nxt_state.irq_pre = irq_live && higher_group;
    end

    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign REG_RDATA = state_ff.rdata;
    assign CAL_ON = state_ff.cal_on;
    assign ALARM_PIN = state_ff.pin;
    assign ALARM_PIN_OE = state_ff.pin_oe;
    assign IRQ_FLAG = state_ff.flag;
    assign IRQ_REQUEST = state_ff.irq_req;
    assign IRQ_PREEMPT = state_ff.irq_pre;
    assign IRQ_PRIORITY = state_ff.prio;
    assign IRQ_SUBPRIORITY = state_ff.subprio;
    assign IRQ_VECTOR = rta_pkg::ALARM_VECTOR;
    assign IRQ_NUMBER = rta_pkg::ALARM_IRQ_NUM;

endmodule

/* File: test/rta_alarm_irq_monitor.sv */
// assertions for the alarm match and interrupt request block
`timescale 1ns/100ps
module rta_alarm_irq_monitor (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic [31:0] CAL_TIME,
    input wire logic [31:0] CAL_DATE,
    input wire logic [14:0] CAL_PRESCALER,
    input wire logic CAL_TICK,
    input wire logic [2:0] CPU_IPL,
    input wire logic CAL_ON,
    input wire logic ALARM_PIN,
    input wire logic ALARM_PIN_OE,
    input wire logic IRQ_FLAG,
    input wire logic IRQ_REQUEST,
    input wire logic IRQ_PREEMPT,
    input wire logic [2:0] IRQ_PRIORITY,
    input wire logic [1:0] IRQ_SUBPRIORITY,
    input wire logic [5:0] IRQ_VECTOR,
    input wire logic [5:0] IRQ_NUMBER
);
    logic ie_ff;
    always_ff @(posedge CLOCK)
    begin
        if (SYS_RST)
            ie_ff <= 1'b0;
        else if (REG_WR && REG_ADDR == rta_pkg::OFS_IRQ_ENABLE)
            ie_ff <= REG_WDATA[rta_pkg::IE_ALARM];
    end
    default clocking mon_cb @(posedge CLOCK);
    endclocking
    default disable iff (SYS_RST);
    property p_ident;
        IRQ_VECTOR == 6'h23 && IRQ_NUMBER == 6'h2F;
    endproperty
    a_ident: assert property (p_ident)
        else $error("alarm vector or number wrong");
    property p_req_src;
        IRQ_REQUEST |-> $past(IRQ_FLAG) && $past(IRQ_PRIORITY) != 3'h0;
    endproperty
    a_req_src: assert property (p_req_src)
        else $error("request without flag or priority");
    property p_req_on;
        IRQ_FLAG && ie_ff && IRQ_PRIORITY != 3'h0 |=> IRQ_REQUEST;
    endproperty
    a_req_on: assert property (p_req_on)
        else $error("enabled flag gave no request");
    property p_req_off;
        !ie_ff |=> !IRQ_REQUEST;
    endproperty
    a_req_off: assert property (p_req_off)
        else $error("request while enable clear");
    property p_prio_zero;
        IRQ_PRIORITY == 3'h0 |=> !IRQ_REQUEST;
    endproperty
    a_prio_zero: assert property (p_prio_zero)
        else $error("request at priority zero");
    property p_preempt;
        IRQ_PREEMPT |-> $past(IRQ_PRIORITY) > $past(CPU_IPL);
    endproperty
    a_preempt: assert property (p_preempt)
        else $error("preempt without higher group");
    property p_flag_keep;
        IRQ_FLAG && !(REG_WR && REG_ADDR == rta_pkg::OFS_IRQ_FLAG) |=> IRQ_FLAG;
    endproperty
    a_flag_keep: assert property (p_flag_keep)
        else $error("flag cleared by hardware");
    property p_flag_set;
        $rose(IRQ_FLAG) |-> $past(CAL_TICK)
            || ($past(REG_WR) && $past(REG_ADDR) == rta_pkg::OFS_IRQ_FLAG);
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag set off a calendar tick");
    property p_pin_cause;
        $changed(ALARM_PIN) |-> $past(CAL_TICK, 2) || $past(REG_WR, 2) || $past(CAL_TICK)
            || $past(REG_WR);
    endproperty
    a_pin_cause: assert property (p_pin_cause)
        else $error("pin moved without event");
    c_flag: cover property ($rose(IRQ_FLAG));
    c_preempt: cover property ($rose(IRQ_PREEMPT));
    c_pin: cover property ($changed(ALARM_PIN));
endmodule
bind rta_alarm_irq rta_alarm_irq_monitor mon_u (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .CAL_TIME(CAL_TIME), .CAL_DATE(CAL_DATE),
    .CAL_PRESCALER(CAL_PRESCALER), .CAL_TICK(CAL_TICK), .CPU_IPL(CPU_IPL), .CAL_ON(CAL_ON),
    .ALARM_PIN(ALARM_PIN), .ALARM_PIN_OE(ALARM_PIN_OE), .IRQ_FLAG(IRQ_FLAG),
    .IRQ_REQUEST(IRQ_REQUEST), .IRQ_PREEMPT(IRQ_PREEMPT), .IRQ_PRIORITY(IRQ_PRIORITY),
    .IRQ_SUBPRIORITY(IRQ_SUBPRIORITY), .IRQ_VECTOR(IRQ_VECTOR), .IRQ_NUMBER(IRQ_NUMBER));

/* File: test/rta_cpu_model.sv */
// interrupt controller and cpu model taking the alarm interrupt
`timescale 1ns/100ps
module rta_cpu_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic irq_request,
    input wire logic irq_preempt,
    input wire logic [2:0] irq_priority,
    input wire logic [2:0] base_ipl,
    output logic [2:0] cpu_ipl
);
    always_ff @(posedge clock)
    begin
        if (rst)
            cpu_ipl <= 3'h0;
        else if (!irq_request)
            cpu_ipl <= base_ipl; // service ends once software clears the flag
        else if (irq_preempt && irq_priority > cpu_ipl)
            cpu_ipl <= irq_priority; // enter service at the alarm group
    end
endmodule

/* File: test/tb_rta_alarm_irq.sv */
// self-checking bench for the alarm match and interrupt request block
`timescale 1ns/100ps
module tb_rta_alarm_irq;
    logic CLOCK = 1'b0;
    logic SYS_RST = 1'b1;
    logic [7:0] REG_ADDR = 8'h00;
    logic [31:0] REG_WDATA = 32'h0;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [31:0] REG_RDATA;
    logic [31:0] CAL_TIME = 32'h0;
    logic [31:0] CAL_DATE = 32'h0610_2705;
    logic [14:0] CAL_PRESCALER = 15'h0;
    logic CAL_TICK = 1'b0;
    logic [2:0] base_ipl = 3'h0;
    logic [2:0] CPU_IPL;
    logic [2:0] IRQ_PRIORITY;
    logic [1:0] IRQ_SUBPRIORITY;
    logic [5:0] IRQ_VECTOR;
    logic [5:0] IRQ_NUMBER;
    logic CAL_ON, ALARM_PIN, ALARM_PIN_OE, IRQ_FLAG, IRQ_REQUEST, IRQ_PREEMPT;
    int err_total = 0;
    int cmp_count = 0;
    always #25 CLOCK = ~CLOCK;
    rta_alarm_irq dut_u (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .CAL_TIME(CAL_TIME), .CAL_DATE(CAL_DATE), .CAL_PRESCALER(CAL_PRESCALER),
        .CAL_TICK(CAL_TICK), .CPU_IPL(CPU_IPL), .CAL_ON(CAL_ON), .ALARM_PIN(ALARM_PIN),
        .ALARM_PIN_OE(ALARM_PIN_OE), .IRQ_FLAG(IRQ_FLAG), .IRQ_REQUEST(IRQ_REQUEST),
        .IRQ_PREEMPT(IRQ_PREEMPT), .IRQ_PRIORITY(IRQ_PRIORITY),
        .IRQ_SUBPRIORITY(IRQ_SUBPRIORITY), .IRQ_VECTOR(IRQ_VECTOR), .IRQ_NUMBER(IRQ_NUMBER));
    rta_cpu_model cpu_u (.clock(CLOCK), .rst(SYS_RST), .irq_request(IRQ_REQUEST),
        .irq_preempt(IRQ_PREEMPT), .irq_priority(IRQ_PRIORITY), .base_ipl(base_ipl),
        .cpu_ipl(CPU_IPL));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLOCK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLOCK);
        REG_WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge CLOCK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLOCK);
        REG_RD <= 1'b0;
        #1;
        chk(REG_RDATA & m, e);
    endtask
    task automatic tick(input logic [31:0] t, input logic [14:0] p);
        @(posedge CLOCK);
        CAL_TIME <= t;
        CAL_PRESCALER <= p;
        CAL_TICK <= 1'b1;
        @(posedge CLOCK);
        CAL_TICK <= 1'b0;
    endtask
    task automatic settle;
        repeat (3) @(posedge CLOCK);
        #1;
    endtask
    task automatic alarm(input logic [31:0] t);
        tick(t, 15'h0000);
        tick(t, 15'h0001);
        settle;
    endtask
    task automatic wrap_up;
        if (err_total == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_reset;
        rd(rta_pkg::OFS_ALARM_CTRL, 32'hFFFF_FFFF, 32'h0);
        rd(8'h3C, 32'hFFFF_FFFF, 32'h0);
        chk(IRQ_VECTOR, 32'h23);
        chk(IRQ_NUMBER, 32'h2F);
    endtask
    task automatic t_one_time;
        wr(rta_pkg::OFS_CAL_CTRL, 32'h0000_8001);
        wr(rta_pkg::OFS_IRQ_PRIORITY, 32'h0D00_0000);
        wr(rta_pkg::OFS_IRQ_ENABLE, 32'h0000_8000);
        wr(rta_pkg::OFS_ALARM_TIME, 32'h1015_0000);
        wr(rta_pkg::OFS_ALARM_DATE, 32'h0610_2705);
        wr(rta_pkg::OFS_ALARM_CTRL, 32'h0000_8600);
        settle;
        chk(IRQ_PRIORITY, 32'h3);
        chk(IRQ_SUBPRIORITY, 32'h1);
        tick(32'h1014_5900, 15'h7FFF);
        tick(32'h1015_0000, 15'h0000);
        settle;
        chk(IRQ_FLAG, 32'h0);
        tick(32'h1015_0000, 15'h0001);
        settle;
        chk(IRQ_FLAG, 32'h1);
        chk(IRQ_REQUEST, 32'h1);
        chk(CPU_IPL, 32'h3);
        rd(rta_pkg::OFS_ALARM_CTRL, 32'hFFFF_FFFF, 32'h0000_0600);
        wr(rta_pkg::OFS_IRQ_FLAG, 32'h0);
        settle;
        chk(IRQ_FLAG, 32'h0);
        chk(CPU_IPL, 32'h0);
        alarm(32'h1015_0000);
        chk(IRQ_FLAG, 32'h0);
    endtask
    task automatic t_endless;
        base_ipl <= 3'h6;
        wr(rta_pkg::OFS_IRQ_PRIORITY, 32'h0);
        wr(rta_pkg::OFS_ALARM_CTRL, 32'h0000_E100);
        settle;
        chk(ALARM_PIN, 32'h1);
        alarm(32'h1200_0000);
        chk(ALARM_PIN, 32'h0);
        chk(IRQ_FLAG, 32'h1);
        chk(IRQ_REQUEST, 32'h0);
        rd(rta_pkg::OFS_ALARM_CTRL, 32'h0000_EFFF, 32'h0000_E1FF);
        alarm(32'h1200_0000);
        chk(ALARM_PIN, 32'h1);
        rd(rta_pkg::OFS_ALARM_CTRL, 32'h0000_EFFF, 32'h0000_E1FE);
        wr(rta_pkg::OFS_IRQ_PRIORITY, 32'h1400_0000);
        settle;
        chk(IRQ_REQUEST, 32'h1);
        chk(CPU_IPL, 32'h6);
        chk(IRQ_PREEMPT, 32'h0);
        wr(rta_pkg::OFS_IRQ_PRIORITY, 32'h1B00_0000);
        settle;
        chk(IRQ_PREEMPT, 32'h0);
        chk(CPU_IPL, 32'h6);
        wr(rta_pkg::OFS_IRQ_PRIORITY, 32'h1C00_0000);
        settle;
        chk(CPU_IPL, 32'h7);
        wr(rta_pkg::OFS_IRQ_FLAG, 32'h0);
        rd(rta_pkg::OFS_ALARM_CTRL, 32'h0000_1000, 32'h0);
        wr(rta_pkg::OFS_ALARM_CTRL, 32'h0);
        settle;
        chk(ALARM_PIN, 32'h0);
    endtask
    task automatic t_mask;
        wr(rta_pkg::OFS_ALARM_TIME, 32'h0000_3000);
        wr(rta_pkg::OFS_ALARM_CTRL, 32'h0000_8305);
        alarm(32'h1200_2900);
        chk(IRQ_FLAG, 32'h0);
        alarm(32'h1200_3000);
        chk(IRQ_FLAG, 32'h1);
        rd(rta_pkg::OFS_ALARM_CTRL, 32'h0000_EFFF, 32'h0000_8304);
        wr(rta_pkg::OFS_IRQ_FLAG, 32'h0);
        rd(rta_pkg::OFS_ALARM_CTRL, 32'h0000_1000, 32'h0);
        wr(rta_pkg::OFS_ALARM_CTRL, 32'h0000_8A00);
        alarm(32'h1200_3000);
        chk(IRQ_FLAG, 32'h0);
    endtask
    task automatic t_seconds;
        wr(rta_pkg::OFS_CAL_CTRL, 32'h0000_8081);
        tick(32'h1200_3000, 15'h4000);
        settle;
        chk(ALARM_PIN, 32'h0);
        tick(32'h1200_3000, 15'h0000);
        settle;
        chk(ALARM_PIN, 32'h1);
        chk(ALARM_PIN_OE, 32'h1);
        chk(CAL_ON, 32'h1);
    endtask
    initial
    begin
        repeat (12) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        t_reset;
        t_one_time;
        t_endless;
        t_mask;
        t_seconds;
        wrap_up;
    end
    initial
    begin
        repeat (20000) @(posedge CLOCK);
        err_total++;
        wrap_up;
    end
endmodule
